// *** inc/otp_pkg.sv ***
// Constants for the over-temperature protection sequencer.
// Assumes a 200 MHz hclk and a single AHB-Lite master.
package otp_pkg;
    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ          = 200;
    localparam int OT_FILTER_US     = 1000;
    localparam int OT_FILTER_CYC    = OT_FILTER_US * CLK_MHZ;
    localparam int OT_RELEASE_US    = 8;
    localparam int OT_RELEASE_CYC   = OT_RELEASE_US * CLK_MHZ;
    localparam int UV_FILTER_US     = 20;
    localparam int UV_FILTER_CYC    = UV_FILTER_US * CLK_MHZ;
    localparam int OT_HOLD_US       = 2000;
    localparam int OT_HOLD_CYC      = OT_HOLD_US * CLK_MHZ;
    localparam int UV_HOLD_US       = 2000;
    localparam int UV_HOLD_CYC      = UV_HOLD_US * CLK_MHZ;
    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATE  = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MK = 8'h0C;
    // Control fields
    localparam int CTRL_EN_BIT        = 0;
    localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
    localparam logic [31:0] MASK_RST  = 32'h0000_0000;
    // Status and interrupt fields
    localparam int EV_OT_TRIP  = 0;
    localparam int EV_UV_TRIP  = 1;
    localparam int EV_WARN     = 2;
    localparam int EV_RELEASE  = 3;
    localparam int EV_W        = 4;
    typedef enum logic [1:0] {OTP_S_IDLE, OTP_S_OT, OTP_S_UV} otp_state_e;
endpackage

// *** rtl/otp_core.sv ***
// Over-temperature and undervoltage protection sequencer with AHB-Lite registers.
// Assumes comparator inputs already synchronous to hclk.
//
// Summary of operation
// R1: Trip after over-temperature lasting 1 ms
// R2: Hold protection for full alarm hold
// R3: After hold, release only with gate off
// R4: Gate still on keeps protection after hold
// R5: Hot above release level keeps protection
// R6: One alarm pulse of hold length
// R7: Short over-temperature spikes never trip
// R8: Filter reset after 8 us cool
// R9: Undervoltage alarm suppressed during thermal hold
// R10: Clear needs gate off and cooled
// R11: Undervoltage 20 us after clear trips alarm
// R12: Undervoltage ends after hold, gate off, recovered
// R13: Warning output low at warning level
// R14: Warning returns high when cooled
// R15: Warning precedes shutdown, no switching stop
// R16: Trip during warning stops switching
// R17: Undervoltage shorter than 20 us ignored
// R18: Timers parameterised in cycles, cleared at reset
// R19: Controller drives gate off on alarm
`timescale 1ns/1ps
module otp_core #(
    parameter int OT_FILTER_CYC  = otp_pkg::OT_FILTER_CYC,
    parameter int OT_RELEASE_CYC = otp_pkg::OT_RELEASE_CYC,
    parameter int UV_FILTER_CYC  = otp_pkg::UV_FILTER_CYC,
    parameter int OT_HOLD_CYC    = otp_pkg::OT_HOLD_CYC,
    parameter int UV_HOLD_CYC    = otp_pkg::UV_HOLD_CYC
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Sensing comparators and gate command
    input  wire logic        chip_temp_above_trip,
    input  wire logic        chip_temp_above_release,
    input  wire logic        chip_temp_above_warning,
    input  wire logic        supply_below_uv,
    input  wire logic        supply_above_uv_release,
    input  wire logic        gate_command_input,
    // Device outputs
    output logic             gate_drive,
    output logic             soft_turnoff,
    output logic             fault_alarm_output,
    output logic             temp_warning_output_n,
    output logic             irq
);
    // ----------------------------------------------------------------
    // Counter widths
    // ----------------------------------------------------------------
    localparam int CW = 32;

    function automatic logic [CW-1:0] cnt_inc(input logic [CW-1:0] c);
        cnt_inc = c + 32'h0000_0001;
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    otp_pkg::otp_state_e          state_r, state_nxt;
    logic [CW-1:0]                ot_filt_r, ot_cool_r, uv_filt_r, hold_r;
    logic [CW-1:0]                ot_filt_nxt, ot_cool_nxt, uv_filt_nxt, hold_nxt;
    logic                         alarm_r, alarm_nxt;
    logic                         warn_r;
    logic [31:0]                  ctrl_r, mask_r;
    logic [otp_pkg::EV_W-1:0]     stat_r;
    logic                         ph_valid_r, ph_write_r;
    logic [7:0]                   ph_addr_r;

    // ----------------------------------------------------------------
    // Detection filters
    // ----------------------------------------------------------------
    wire enable       = ctrl_r[otp_pkg::CTRL_EN_BIT];
    wire ot_detect    = (ot_filt_r >= CW'(OT_FILTER_CYC)) && chip_temp_above_trip; // [R1] [R7]
    wire uv_detect    = (uv_filt_r >= CW'(UV_FILTER_CYC)) && supply_below_uv;      // [R11] [R17]
    wire hold_done    = (hold_r == '0);
    wire ot_trip      = enable && (state_r != otp_pkg::OTP_S_OT) && ot_detect;     // [R16]
    wire uv_trip      = enable && (state_r == otp_pkg::OTP_S_IDLE) && !ot_detect && uv_detect;
    wire ot_release   = hold_done && !gate_command_input && !chip_temp_above_release; // [R3] [R4] [R5] [R10]
    wire uv_release   = hold_done && !gate_command_input && supply_above_uv_release;  // [R12]

    // Over-temperature filter counts above trip; an 8 us cool spell restarts it
    always_comb
    begin
        ot_cool_nxt = '0;
        ot_filt_nxt = ot_filt_r;
        if (!chip_temp_above_release)
        begin
            ot_cool_nxt = cnt_inc(ot_cool_r);
        end
        if (chip_temp_above_trip)
        begin
            if (ot_filt_r < CW'(OT_FILTER_CYC))
                ot_filt_nxt = cnt_inc(ot_filt_r);
        end
        else
        begin
            // Falling below trip ends the continuous run, so no spike can trip [R7]
            ot_filt_nxt = '0;
        end
        if (ot_cool_r >= CW'(OT_RELEASE_CYC))
            ot_filt_nxt = '0; // [R8]
        if (state_r == otp_pkg::OTP_S_OT)
            ot_filt_nxt = '0;
    end

    // Undervoltage filter counts an uninterrupted low supply
    always_comb
    begin
        uv_filt_nxt = '0;
        if (supply_below_uv && uv_filt_r < CW'(UV_FILTER_CYC))
            uv_filt_nxt = cnt_inc(uv_filt_r); // [R17]
        else if (supply_below_uv)
            uv_filt_nxt = uv_filt_r;
    end

    // ----------------------------------------------------------------
    // Protection sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        hold_nxt  = hold_done ? hold_r : hold_r - 32'h0000_0001;
        alarm_nxt = alarm_r && !hold_done;
        case (state_r)
            otp_pkg::OTP_S_IDLE:
            begin
                if (ot_trip)
                begin
                    state_nxt = otp_pkg::OTP_S_OT;
                    hold_nxt  = CW'(OT_HOLD_CYC); // [R2]
                    alarm_nxt = 1'b1;             // [R1] [R6]
                end
                else if (uv_trip)
                begin
                    state_nxt = otp_pkg::OTP_S_UV;
                    hold_nxt  = CW'(UV_HOLD_CYC);
                    alarm_nxt = 1'b1;             // [R11]
                end
            end
            otp_pkg::OTP_S_OT:
            begin
                // Undervoltage is not sequenced here, so its alarm never shows [R9]
                if (ot_release)
                    state_nxt = otp_pkg::OTP_S_IDLE;
            end
            otp_pkg::OTP_S_UV:
            begin
                if (ot_trip)
                begin
                    state_nxt = otp_pkg::OTP_S_OT;
                    hold_nxt  = CW'(OT_HOLD_CYC);
                    alarm_nxt = 1'b1;
                end
                else if (uv_release)
                    state_nxt = otp_pkg::OTP_S_IDLE;
            end
            default:
                state_nxt = otp_pkg::OTP_S_IDLE;
        endcase
    end

    // All timers clear at reset [R18]
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_r   <= otp_pkg::OTP_S_IDLE;
            ot_filt_r <= '0;
            ot_cool_r <= '0;
            uv_filt_r <= '0;
            hold_r    <= '0;
            alarm_r   <= 1'b0;
            warn_r    <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            ot_filt_r <= ot_filt_nxt;
            ot_cool_r <= ot_cool_nxt;
            uv_filt_r <= uv_filt_nxt;
            hold_r    <= hold_nxt;
            alarm_r   <= alarm_nxt;
            warn_r    <= chip_temp_above_warning; // [R13] [R14]
        end
    end

    // Outputs: warning alone never blocks the gate [R15]
    wire protecting = (state_r != otp_pkg::OTP_S_IDLE);
    assign gate_drive            = gate_command_input && !protecting; // [R16]
    assign soft_turnoff          = protecting;
    assign fault_alarm_output    = alarm_r;
    assign temp_warning_output_n = !warn_r; // [R13]

    // ----------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // ----------------------------------------------------------------
    wire take      = hsel && hready && htrans[1];
    wire wr_ctrl   = ph_valid_r && ph_write_r && (ph_addr_r == otp_pkg::ADDR_CTRL);
    wire wr_mask   = ph_valid_r && ph_write_r && (ph_addr_r == otp_pkg::ADDR_IRQ_MK);
    wire rd_stat   = ph_valid_r && !ph_write_r && (ph_addr_r == otp_pkg::ADDR_IRQ_ST);
    // Event bits placed by their named positions, so the map lives in one place
    logic [otp_pkg::EV_W-1:0] ev;
    assign ev[otp_pkg::EV_OT_TRIP] = ot_trip;
    assign ev[otp_pkg::EV_UV_TRIP] = uv_trip;
    assign ev[otp_pkg::EV_WARN]    = chip_temp_above_warning & !warn_r;
    assign ev[otp_pkg::EV_RELEASE] = ot_release & (state_r == otp_pkg::OTP_S_OT);
    wire [31:0] state_word = {27'h0, warn_r, alarm_r, gate_drive, 2'(state_r)};

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = |(stat_r & mask_r[otp_pkg::EV_W-1:0]);

    // Read data mux; unmapped addresses read zero
    always_comb
    begin
        if (ph_addr_r == otp_pkg::ADDR_CTRL)
            hrdata = ctrl_r;
        else if (ph_addr_r == otp_pkg::ADDR_STATE)
            hrdata = state_word;
        else if (ph_addr_r == otp_pkg::ADDR_IRQ_ST)
            hrdata = {28'h0, stat_r};
        else if (ph_addr_r == otp_pkg::ADDR_IRQ_MK)
            hrdata = mask_r;
        else
            hrdata = 32'h0000_0000;
    end

    // Address phase capture and register writes; events win over read clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_valid_r <= 1'b0;
            ph_write_r <= 1'b0;
            ph_addr_r  <= 8'h00;
            ctrl_r     <= otp_pkg::CTRL_RST;
            mask_r     <= otp_pkg::MASK_RST;
            stat_r     <= '0;
        end
        else
        begin
            ph_valid_r <= take;
            ph_write_r <= hwrite;
            ph_addr_r  <= take ? haddr : ph_addr_r;
            if (wr_ctrl)
                ctrl_r <= hwdata;
            if (wr_mask)
                mask_r <= hwdata;
            stat_r <= (rd_stat ? '0 : stat_r) | ev;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_TRIP_ALARM: assert property (@(posedge hclk) disable iff (!hresetn) // [R1]
        ot_trip |=> fault_alarm_output && soft_turnoff)
        else $error("trip did not raise alarm");
    AST_HOLD_KEEP: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
        (state_r == otp_pkg::OTP_S_OT && !hold_done) |=> state_r == otp_pkg::OTP_S_OT)
        else $error("left protection within hold");
    AST_GATE_ON_KEEP: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
        (state_r == otp_pkg::OTP_S_OT && gate_command_input) |=> protecting)
        else $error("released with gate on");
    AST_HOT_KEEP: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
        (state_r == otp_pkg::OTP_S_OT && chip_temp_above_release) |=> state_r == otp_pkg::OTP_S_OT)
        else $error("released while hot");
    AST_ONE_PULSE: assert property (@(posedge hclk) disable iff (!hresetn) // [R6]
        $fell(fault_alarm_output) |-> ##1 !fault_alarm_output)
        else $error("alarm pulsed twice");
    AST_NO_SPIKE: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
        !chip_temp_above_trip |=> !ot_detect)
        else $error("spike detected");
    AST_UV_MASK: assert property (@(posedge hclk) disable iff (!hresetn) // [R9]
        (state_r == otp_pkg::OTP_S_OT) |-> !uv_trip)
        else $error("undervoltage during thermal hold");
    AST_WARN: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
        chip_temp_above_warning |=> !temp_warning_output_n)
        else $error("warning not driven");
    AST_WARN_GATE: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
        (!protecting && gate_command_input) |-> gate_drive)
        else $error("gate blocked without protection");

    // ----------------------------------------------------------------
    // Release, filter, undervoltage, warning, gate, hold and reset checks
    // ----------------------------------------------------------------
    // A satisfied release condition must actually free the switch
    AST_RELEASE_GATE_OFF: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
        (state_r == otp_pkg::OTP_S_OT && ot_release) |=> state_r == otp_pkg::OTP_S_IDLE)
        else $error("release condition ignored");
    // Leaving thermal protection needs hold over, gate off and a cooled chip
    AST_CLEAR_NEEDS: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
        (state_r == otp_pkg::OTP_S_OT && state_nxt == otp_pkg::OTP_S_IDLE)
        |-> (hold_done && !gate_command_input && !chip_temp_above_release))
        else $error("thermal clear without its conditions");
    // A long cool spell must empty the detection filter
    AST_FILTER_RESET: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
        (ot_cool_r >= CW'(OT_RELEASE_CYC)) |=> ot_filt_r == '0)
        else $error("filter kept after cool spell");
    // A filtered undervoltage enters its own protection with the alarm
    AST_UV_TRIP: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
        uv_trip |=> fault_alarm_output && state_r == otp_pkg::OTP_S_UV)
        else $error("undervoltage trip lost");
    // Undervoltage protection stays until its own release condition or an over-temperature trip
    AST_UV_END: assert property (@(posedge hclk) disable iff (!hresetn) // [R12]
        (state_r == otp_pkg::OTP_S_UV && !uv_release && !ot_trip) |=> state_r == otp_pkg::OTP_S_UV)
        else $error("undervoltage released early");
    // Warning output goes back high once the chip cools below warning
    AST_WARN_OFF: assert property (@(posedge hclk) disable iff (!hresetn) // [R14]
        !chip_temp_above_warning |=> temp_warning_output_n)
        else $error("warning stuck low");
    // Any protection state blocks the gate
    AST_TRIP_STOP: assert property (@(posedge hclk) disable iff (!hresetn) // [R16]
        protecting |-> !gate_drive)
        else $error("gate driven during protection");
    // Protection within the hold always shows a soft turn-off
    AST_HOLD_SOFT: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
        (state_r == otp_pkg::OTP_S_OT && !hold_done) |-> soft_turnoff)
        else $error("no soft turn-off within hold");
    // An interrupted low supply can never count as filtered
    AST_UV_SHORT: assert property (@(posedge hclk) disable iff (!hresetn) // [R17]
        !supply_below_uv |=> !uv_detect)
        else $error("short undervoltage detected");
    // Hold and filter timers read zero while reset is held
    AST_RESET_CLEAR: assert property (@(posedge hclk) // [R18]
        !hresetn |-> (hold_r == '0 && ot_filt_r == '0 && uv_filt_r == '0))
        else $error("timer not cleared in reset");

    // ----------------------------------------------------------------
    // Alarm pulse length
    // ----------------------------------------------------------------
    // Checking-only counter; a new trip restarts it since a trip reloads the hold
    localparam int LONG_HOLD = (OT_HOLD_CYC > UV_HOLD_CYC) ? OT_HOLD_CYC : UV_HOLD_CYC;
    logic [CW-1:0] alarm_len_r;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            alarm_len_r <= '0;
        else if (!alarm_r || ot_trip || uv_trip)
            alarm_len_r <= '0;
        else
            alarm_len_r <= cnt_inc(alarm_len_r);
    end
    // However long protection lasts, the pulse ends with the hold
    AST_ALARM_LEN: assert property (@(posedge hclk) disable iff (!hresetn) // [R6]
        alarm_len_r <= CW'(LONG_HOLD + 1))
        else $error("alarm longer than hold");
    // Every alarm rise starts with a loaded hold timer
    AST_ALARM_HOLD: assert property (@(posedge hclk) disable iff (!hresetn) // [R6]
        $rose(fault_alarm_output) |-> !hold_done)
        else $error("alarm raised without hold");
endmodule

// *** test/otp_ctl_model.sv ***
// Behavioural inverter controller on the gate command side.
// Assumes the alarm output and reset of the protection sequencer.
`timescale 1ns/1ps
module otp_ctl_model (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Bench commands; obey low makes it ignore alarms on purpose
    input  wire logic want_on,
    input  wire logic obey,
    // Device side
    input  wire logic fault_alarm_output,
    output logic      gate_command_input
);
    logic fault_r;
    // Latch an alarm as a fault until the bench withdraws the command
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            fault_r <= 1'b0;
        else if (fault_alarm_output && obey)
            fault_r <= 1'b1;
        else if (!want_on)
            fault_r <= 1'b0;
    end
    // Gate follows the command unless a fault is latched
    assign gate_command_input = want_on && !fault_r;
endmodule

// *** test/tb.sv ***
// Self-checking bench for the protection sequencer.
// Assumes short timer parameters so the run stays brief.
`timescale 1ns/1ps
module tb;
    localparam int FLT = 20;
    localparam int HLD = 30;
    logic        hclk, hresetn, hsel, hwrite, hrdy, hresp, rd_dp, al_p;
    logic        t_trip, t_rel, t_warn, uv, uv_rel, want_on, obey, gate_cmd;
    logic        gate_drive, soft_turnoff, fault_alarm_output, temp_warning_output_n, irq;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, seed;
    logic [31:0] rd_q[$];
    int          al_q[$];
    int          al_w, fail_count, num_checks, n;
    // Device with shortened counts
    otp_core #(.OT_FILTER_CYC(FLT), .OT_RELEASE_CYC(4), .UV_FILTER_CYC(8), .OT_HOLD_CYC(HLD),
        .UV_HOLD_CYC(HLD)) i_otp_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hrdy), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hrdy), .hresp(hresp), .chip_temp_above_trip(t_trip), .chip_temp_above_release(t_rel),
        .chip_temp_above_warning(t_warn), .supply_below_uv(uv), .supply_above_uv_release(uv_rel),
        .gate_command_input(gate_cmd), .gate_drive(gate_drive), .soft_turnoff(soft_turnoff),
        .fault_alarm_output(fault_alarm_output), .temp_warning_output_n(temp_warning_output_n), .irq(irq));
    otp_ctl_model i_otp_ctl_model (.hclk(hclk), .hresetn(hresetn), .want_on(want_on), .obey(obey),
        .fault_alarm_output(fault_alarm_output), .gate_command_input(gate_cmd));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_up;
        fail_count++;
        $display("[FAIL] %0t wait ran out", $time);
        close_out();
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge hclk);
    endtask
    // Bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int k;
        k = 0;
        @(posedge hclk);
        while (hrdy !== 1'b1)
        begin
            @(posedge hclk);
            k++;
            if (k > 50)
                give_up();
        end
    endtask
    // One single word transfer; read data is compared by the monitor
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp  <= !w;
        wait_rdy();
        rd_dp  <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask
    // Bounded wait for an alarm level, then let the edge settle
    task automatic wait_al(input logic lvl, input int lim);
        int k;
        k = 0;
        while (fault_alarm_output !== lvl)
        begin
            @(posedge hclk);
            k++;
            if (k > lim)
                give_up();
        end
        #1;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Clock at 200 MHz
    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // Monitor: read data, alarm rises against notes, alarm pulse length
    always @(posedge hclk)
    begin
        al_p <= fault_alarm_output;
        al_w <= (fault_alarm_output === 1'b1) ? al_w + 1 : 0;
        if (rd_dp === 1'b1 && hrdy === 1'b1 && rd_q.size() > 0)
            chk(hrdata, rd_q.pop_front());
        if (fault_alarm_output === 1'b1 && al_p === 1'b0)
        begin
            chk(32'(al_q.size()), 32'd1);
            if (al_q.size() > 0)
                void'(al_q.pop_front());
        end
        if (fault_alarm_output === 1'b0 && al_p === 1'b1)
            chk(32'(al_w >= HLD && al_w <= HLD + 2), 32'd1);
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {hsel, hwrite, rd_dp, t_trip, t_rel, t_warn, uv, want_on, al_w} = '0;
        {htrans, haddr, hwdata} = '0;
        {uv_rel, obey} = 2'b11;
        seed = 32'h7A414E8B;
        hresetn = 1'b0;
        cyc(6);
        #1 chk({fault_alarm_output, temp_warning_output_n, soft_turnoff, irq}, 32'h4);
        cyc(1);
        hresetn <= 1'b1;
        rd(otp_pkg::ADDR_CTRL, otp_pkg::CTRL_RST);
        rd(otp_pkg::ADDR_IRQ_MK, otp_pkg::MASK_RST);
        rd(8'h10, 32'h0);
        rd(otp_pkg::ADDR_STATE, 32'h0);
        bus(otp_pkg::ADDR_IRQ_MK, 1'b1, 32'h4);
        rd(otp_pkg::ADDR_IRQ_MK, 32'h4);
        // Short hot spikes with random gate state never trip
        repeat (6)
        begin
            seed = xs(seed);
            n = int'(seed[3:0] % 15) + 1;
            want_on <= seed[9];
            {t_trip, t_rel} <= 2'b11;
            cyc(n);
            {t_trip, t_rel} <= 2'b00;
            cyc(8);
        end
        #1 chk(soft_turnoff, 32'h0);
        cyc(1);
        // Two runs split by a cool gap longer than the release delay
        {t_trip, t_rel, want_on} <= 3'b111;
        cyc(15);
        {t_trip, t_rel} <= 2'b00;
        cyc(6);
        {t_trip, t_rel} <= 2'b11;
        cyc(15);
        {t_trip, t_rel, t_warn} <= 3'b001;
        cyc(2);
        #1 chk({temp_warning_output_n, gate_drive, irq, soft_turnoff}, 32'h6);
        cyc(1);
        // Trip during warning with the controller ignoring the alarm
        obey <= 1'b0;
        al_q.push_back(1);
        {t_trip, t_rel} <= 2'b11;
        wait_al(1'b1, FLT + 5);
        chk({soft_turnoff, gate_drive}, 32'h2);
        cyc(1);
        {t_trip, t_rel, t_warn, uv} <= 4'b0001;
        cyc(12);
        uv <= 1'b0;
        cyc(2);
        #1 chk({soft_turnoff, temp_warning_output_n}, 32'h3);
        wait_al(1'b0, HLD + 5);
        cyc(3);
        #1 chk(soft_turnoff, 32'h1);
        cyc(1);
        {t_rel, want_on} <= 2'b10;
        cyc(5);
        #1 chk(soft_turnoff, 32'h1);
        cyc(1);
        t_rel <= 1'b0;
        cyc(3);
        #1 chk(soft_turnoff, 32'h0);
        cyc(1);
        // Undervoltage: short dip ignored, long dip trips
        {obey, want_on, uv} <= 3'b111;
        cyc(5);
        uv <= 1'b0;
        cyc(5);
        #1 chk(soft_turnoff, 32'h0);
        cyc(1);
        al_q.push_back(1);
        {uv, uv_rel} <= 2'b10;
        wait_al(1'b1, 15);
        chk(soft_turnoff, 32'h1);
        cyc(1);
        {uv, want_on} <= 2'b00;
        wait_al(1'b0, HLD + 5);
        cyc(3);
        #1 chk(soft_turnoff, 32'h1);
        cyc(1);
        uv_rel <= 1'b1;
        cyc(3);
        #1 chk(soft_turnoff, 32'h0);
        // Sticky status cleared by read drops the interrupt
        rd(otp_pkg::ADDR_IRQ_ST, 32'((1 << otp_pkg::EV_W) - 1));
        rd(otp_pkg::ADDR_IRQ_ST, 32'h0);
        #1 chk(irq, 32'h0);
        cyc(2);
        chk(32'(al_q.size()), 32'h0);
        chk({hresp, hrdy}, 32'h1);
        close_out();
    end
endmodule
